// >>> ppm_pin_mux.sv
// peripheral pin mux for ports m0, p, q, s, t and u
// Notes on behaviour
// - dac two enabled takes m0 as analog
// - motor pwm drives port p by pairs
// - port q 6:4 feed active-low current status
// - port q 3:0 feed motor pwm faults
// - spi enabled owns s7 select, s6 clock
// - s5 mosi: master output, slave input
// - s4 miso: master input, slave output
// - s3, s1 follow serial transmitter enables
// - s2, s0 follow serial receiver enables
// - timer one channels on port t 7:4
// - timer zero channels on port t 3:0
// - general pwm outputs on port u 5:4
// - routing picks timer two or pwm, u3:0
// - port u 7:6 always general purpose
// - reset leaves every pin undriven input
module ppm_pin_mux (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic [37:0] pad_in_i,
   output logic [37:0] pad_out_o,
   output logic [37:0] pad_oe_o,
   output logic [37:0] pin_o,
   output logic port_m0_analog_sel_o,
   input wire logic port_m0_data_i,
   input wire logic port_m0_dir_i,
   input wire logic [5:0] port_p_data_i,
   input wire logic [5:0] port_p_dir_i,
   input wire logic [6:0] port_q_data_i,
   input wire logic [6:0] port_q_dir_i,
   input wire logic [7:0] port_s_data_i,
   input wire logic [7:0] port_s_dir_i,
   input wire logic [7:0] port_t_data_i,
   input wire logic [7:0] port_t_dir_i,
   input wire logic [7:0] port_u_data_i,
   input wire logic [7:0] port_u_dir_i,
   input wire logic second_dac_en_i,
   input wire logic pmf_en_i,
   input wire logic [2:0] pmf_pair_en_i,
   input wire logic [5:0] motor_pwm_i,
   input wire logic pmf_status_en_i,
   input wire logic [3:0] pmf_fault_en_i,
   output logic [2:0] current_status_n_o,
   output logic [3:0] fault_o,
   input wire logic spi_en_i,
   input wire logic spi_master_i,
   input wire logic spi_ss_out_i,
   input wire logic spi_ss_oe_i,
   input wire logic spi_sck_out_i,
   input wire logic spi_mosi_out_i,
   input wire logic spi_miso_out_i,
   output logic spi_ss_in_o,
   output logic spi_sck_in_o,
   output logic spi_mosi_in_o,
   output logic spi_miso_in_o,
   input wire logic serial_interface_zero_tx_en_i,
   input wire logic serial_interface_zero_tx_i,
   input wire logic serial_interface_zero_rx_en_i,
   output logic serial_interface_zero_rx_o,
   input wire logic serial_interface_one_tx_en_i,
   input wire logic serial_interface_one_tx_i,
   input wire logic serial_interface_one_rx_en_i,
   output logic serial_interface_one_rx_o,
   input wire logic timer_zero_en_i,
   input wire logic [3:0] timer_zero_ch_en_i,
   input wire logic [3:0] timer_zero_out_i,
   input wire logic [3:0] timer_zero_oe_i,
   output logic [3:0] timer_zero_capture_o,
   input wire logic timer_one_en_i,
   input wire logic [3:0] timer_one_ch_en_i,
   input wire logic [3:0] timer_one_out_i,
   input wire logic [3:0] timer_one_oe_i,
   output logic [3:0] timer_one_capture_o,
   input wire logic timer_two_en_i,
   input wire logic [3:0] timer_two_ch_en_i,
   input wire logic [3:0] timer_two_out_i,
   input wire logic [3:0] timer_two_oe_i,
   output logic [3:0] timer_two_capture_o,
   input wire logic pwm_en_i,
   input wire logic [5:0] pwm_ch_en_i,
   input wire logic [5:0] pwm_out_i,
   input wire logic [3:0] routing_select_i
);
   localparam int N = ppm_pkg::NUM_PINS;
   localparam int PS = ppm_pkg::PIN_S;
   localparam int PT = ppm_pkg::PIN_T;
   localparam int PU = ppm_pkg::PIN_U;
   localparam int PQ = ppm_pkg::PIN_Q;

   logic [N-1:0] gpio_data;
   logic [N-1:0] gpio_dir;
   logic [N-1:0] out_next;
   logic [N-1:0] oe_next;
   logic [3:0] timer_two_own;
   logic [3:0] timer_zero_own, timer_one_own;
   logic [3:0] pwm_low_own;

   function automatic logic [3:0] owned(input logic en, input logic [3:0] ch);
      owned = en ? ch : 4'h0;
   endfunction

   assign gpio_data = {port_u_data_i, port_t_data_i, port_s_data_i,
                       port_q_data_i, port_p_data_i, port_m0_data_i};
   assign gpio_dir = {port_u_dir_i, port_t_dir_i, port_s_dir_i,
                      port_q_dir_i, port_p_dir_i, port_m0_dir_i};
   assign timer_zero_own = owned(timer_zero_en_i, timer_zero_ch_en_i);
   assign timer_one_own = owned(timer_one_en_i, timer_one_ch_en_i);
   assign timer_two_own = owned(timer_two_en_i, timer_two_ch_en_i) & routing_select_i;
   assign pwm_low_own = owned(pwm_en_i, pwm_ch_en_i[3:0]) & ~routing_select_i;

   always_comb begin
      // defaults hand every pin to its port, u7:6 never leave it
      out_next = gpio_data;
      oe_next = gpio_dir;
      if (second_dac_en_i) begin
         oe_next[ppm_pkg::PIN_M0] = 1'b0;
      end
      for (int k = 0; k < ppm_pkg::P_WIDTH; k++) begin
         if (pmf_en_i && pmf_pair_en_i[k/2]) begin
            out_next[ppm_pkg::PIN_P+k] = motor_pwm_i[k];
            oe_next[ppm_pkg::PIN_P+k] = 1'b1;
         end
      end
      if (pmf_en_i && pmf_status_en_i) begin
         oe_next[PQ+6 -: 3] = 3'h0;
      end
      for (int k = 0; k < 4; k++) begin
         if (pmf_en_i && pmf_fault_en_i[k]) begin
            oe_next[PQ+k] = 1'b0;
         end
      end
      if (spi_en_i) begin
         out_next[PS+7] = spi_ss_out_i;
         oe_next[PS+7] = spi_ss_oe_i;
         out_next[PS+6] = spi_sck_out_i;
         oe_next[PS+6] = spi_master_i;
         out_next[PS+5] = spi_mosi_out_i;
         oe_next[PS+5] = spi_master_i;
         out_next[PS+4] = spi_miso_out_i;
         oe_next[PS+4] = !spi_master_i;
      end
      if (serial_interface_one_tx_en_i) begin
         out_next[PS+3] = serial_interface_one_tx_i;
         oe_next[PS+3] = 1'b1;
      end
      if (serial_interface_one_rx_en_i) begin
         oe_next[PS+2] = 1'b0;
      end
      if (serial_interface_zero_tx_en_i) begin
         out_next[PS+1] = serial_interface_zero_tx_i;
         oe_next[PS+1] = 1'b1;
      end
      if (serial_interface_zero_rx_en_i) begin
         oe_next[PS] = 1'b0;
      end
      for (int k = 0; k < ppm_pkg::TIM_CH; k++) begin
         if (timer_one_own[k]) begin
            out_next[PT+4+k] = timer_one_out_i[k];
            oe_next[PT+4+k] = timer_one_oe_i[k];
         end
         if (timer_zero_own[k]) begin
            out_next[PT+k] = timer_zero_out_i[k];
            oe_next[PT+k] = timer_zero_oe_i[k];
         end
         if (timer_two_own[k]) begin
            out_next[PU+k] = timer_two_out_i[k];
            oe_next[PU+k] = timer_two_oe_i[k];
         end else if (pwm_low_own[k]) begin
            out_next[PU+k] = pwm_out_i[k];
            oe_next[PU+k] = 1'b1;
         end
      end
      for (int k = 4; k < ppm_pkg::PWM_CH; k++) begin
         if (pwm_en_i && pwm_ch_en_i[k]) begin
            out_next[PU+k] = pwm_out_i[k];
            oe_next[PU+k] = 1'b1;
         end
      end
   end

   ppm_pad_cell #(
      .WIDTH(N)
   ) u_pads (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .out_i(out_next),
      .oe_i(oe_next),
      .pad_in_i(pad_in_i),
      .pad_out_o(pad_out_o),
      .pad_oe_o(pad_oe_o),
      .pin_o(pin_o)
   );

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         port_m0_analog_sel_o <= ppm_pkg::ANALOG_SEL_RST;
      end else begin
         port_m0_analog_sel_o <= second_dac_en_i;
      end
   end

   // peripheral inputs see idle levels unless they own the pin, so a
   // disabled unit never reacts to board noise on a general-purpose pin
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         current_status_n_o <= ppm_pkg::STATUS_N_IDLE;
         fault_o <= ppm_pkg::FAULT_IDLE;
      end else begin
         current_status_n_o <= (pmf_en_i && pmf_status_en_i) ?
                               pin_o[PQ+6 -: 3] : ppm_pkg::STATUS_N_IDLE;
         fault_o <= owned(pmf_en_i, pmf_fault_en_i) & pin_o[PQ+3 -: 4];
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         spi_ss_in_o <= ppm_pkg::LINE_IDLE;
         spi_sck_in_o <= ppm_pkg::LINE_IDLE;
         spi_mosi_in_o <= ppm_pkg::LINE_IDLE;
         spi_miso_in_o <= ppm_pkg::LINE_IDLE;
      end else begin
         spi_ss_in_o <= spi_en_i ? pin_o[PS+7] : ppm_pkg::LINE_IDLE;
         spi_sck_in_o <= spi_en_i ? pin_o[PS+6] : ppm_pkg::LINE_IDLE;
         spi_mosi_in_o <= spi_en_i ? pin_o[PS+5] : ppm_pkg::LINE_IDLE;
         spi_miso_in_o <= spi_en_i ? pin_o[PS+4] : ppm_pkg::LINE_IDLE;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         serial_interface_zero_rx_o <= ppm_pkg::LINE_IDLE;
         serial_interface_one_rx_o <= ppm_pkg::LINE_IDLE;
      end else begin
         serial_interface_zero_rx_o <= serial_interface_zero_rx_en_i ? pin_o[PS] : ppm_pkg::LINE_IDLE;
         serial_interface_one_rx_o <= serial_interface_one_rx_en_i ? pin_o[PS+2] : ppm_pkg::LINE_IDLE;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         timer_zero_capture_o <= ppm_pkg::CAPTURE_IDLE;
         timer_one_capture_o <= ppm_pkg::CAPTURE_IDLE;
         timer_two_capture_o <= ppm_pkg::CAPTURE_IDLE;
      end else begin
         timer_zero_capture_o <= owned(timer_zero_en_i, timer_zero_ch_en_i) & pin_o[PT+3 -: 4];
         timer_one_capture_o <= owned(timer_one_en_i, timer_one_ch_en_i) & pin_o[PT+7 -: 4];
         timer_two_capture_o <= timer_two_own & pin_o[PU+3 -: 4];
      end
   end

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);

   sequence spi_master_on;
      spi_en_i && spi_master_i;
   endsequence

   sequence spi_slave_on;
      spi_en_i && !spi_master_i;
   endsequence

   chk_reset_hiz: assert property (disable iff (1'b0) rst_i |=>
      (pad_oe_o == '0) && !port_m0_analog_sel_o && (fault_o == 4'h0))
      else $error("pin driven or function active after reset cycle");
   chk_dac_analog: assert property (second_dac_en_i |=>
      port_m0_analog_sel_o && !pad_oe_o[ppm_pkg::PIN_M0])
      else $error("m0 not handed to the dac");
   chk_gpio_return: assert property (!second_dac_en_i |=>
      !port_m0_analog_sel_o && pad_oe_o[0] == $past(port_m0_dir_i))
      else $error("m0 not returned to its port");
   chk_pmf_pair_drive: assert property (pmf_en_i && pmf_pair_en_i[0] |=>
      pad_oe_o[1] && pad_out_o[1] == $past(motor_pwm_i[0]))
      else $error("motor pwm pair not driven");
   chk_fault_path: assert property (!$past(rst_i, 3) &&
      $past(pmf_en_i && pmf_fault_en_i[0]) |-> fault_o[0] ==
      $past(pad_in_i[PQ], 3) && !pad_oe_o[PQ])
      else $error("fault input not passed from pin");
   chk_spi_master_dir: assert property (spi_master_on |=>
      pad_oe_o[PS+5] && !pad_oe_o[PS+4] && pad_oe_o[PS+6])
      else $error("spi master pin directions wrong");
   chk_spi_slave_dir: assert property (spi_slave_on |=>
      !pad_oe_o[PS+5] && pad_oe_o[PS+4] && !pad_oe_o[PS+6])
      else $error("spi slave pin directions wrong");
   chk_sci_tx_drive: assert property (serial_interface_zero_tx_en_i |=>
      pad_oe_o[PS+1] && pad_out_o[PS+1] == $past(serial_interface_zero_tx_i))
      else $error("serial zero transmit not on its pin");
   chk_rx_idle: assert property (!serial_interface_one_rx_en_i |=> serial_interface_one_rx_o)
      else $error("receive line not idle while disabled");
   chk_routing_timer: assert property (routing_select_i[0] && timer_two_en_i &&
      timer_two_ch_en_i[0] |=> pad_out_o[PU] == $past(timer_two_out_i[0]) &&
      pad_oe_o[PU] == $past(timer_two_oe_i[0]))
      else $error("timer two not routed to u0");
   chk_u_top_gpio: assert property (1'b1 |=>
      pad_oe_o[PU+7 -: 2] == $past(port_u_dir_i[7:6]) &&
      pad_out_o[PU+7 -: 2] == $past(port_u_data_i[7:6]))
      else $error("u7:6 left general-purpose control");
endmodule

// >>> ppm_pkg.sv
// pin positions, reset values and idle levels for the peripheral pin mux
package ppm_pkg;
   // flat pin vector layout: {port_u, port_t, port_s, port_q, port_p, m0}
   localparam int PIN_M0 = 0;
   localparam int PIN_P = 1;
   localparam int PIN_Q = 7;
   localparam int PIN_S = 14;
   localparam int PIN_T = 22;
   localparam int PIN_U = 30;
   localparam int NUM_PINS = 38;
   localparam int P_WIDTH = 6;
   localparam int Q_WIDTH = 7;
   localparam int PORT_WIDTH = 8;
   localparam int Q_STATUS = 4;
   localparam int TIM_CH = 4;
   localparam int PWM_CH = 6;
   localparam int PWM_PAIRS = 3;
   // values held in reset: every pin undriven, digital input only
   localparam logic [NUM_PINS-1:0] PAD_OE_RST = 38'h00_0000_0000;
   localparam logic [NUM_PINS-1:0] PAD_OUT_RST = 38'h00_0000_0000;
   localparam logic [NUM_PINS-1:0] PIN_SYNC_RST = 38'h00_0000_0000;
   localparam logic ANALOG_SEL_RST = 1'b0;
   // levels shown to a peripheral that does not own its pin
   localparam logic [2:0] STATUS_N_IDLE = 3'h7;
   localparam logic [3:0] FAULT_IDLE = 4'h0;
   localparam logic LINE_IDLE = 1'b1;
   localparam logic [3:0] CAPTURE_IDLE = 4'h0;
endpackage

// >>> ppm_pad_cell.sv
// pad register cell: registered drive and two-stage input synchroniser
module ppm_pad_cell #(
   parameter int WIDTH = 38
) (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic [WIDTH-1:0] out_i,
   input wire logic [WIDTH-1:0] oe_i,
   input wire logic [WIDTH-1:0] pad_in_i,
   output logic [WIDTH-1:0] pad_out_o,
   output logic [WIDTH-1:0] pad_oe_o,
   output logic [WIDTH-1:0] pin_o
);
   logic [WIDTH-1:0] sync1_reg;
   logic [WIDTH-1:0] sync2_reg;

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         pad_oe_o <= WIDTH'(ppm_pkg::PAD_OE_RST);
         pad_out_o <= WIDTH'(ppm_pkg::PAD_OUT_RST);
      end else begin
         pad_oe_o <= oe_i;
         pad_out_o <= out_i;
      end
   end

   // first stage feeds only the second stage
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         sync1_reg <= WIDTH'(ppm_pkg::PIN_SYNC_RST);
         sync2_reg <= WIDTH'(ppm_pkg::PIN_SYNC_RST);
      end else begin
         sync1_reg <= pad_in_i;
         sync2_reg <= sync1_reg;
      end
   end

   assign pin_o = sync2_reg;
endmodule

// >>> ppm_board_model.sv
// board side of the pads: what each pin shows to the chip
module ppm_board_model (
   input wire logic [37:0] pad_out_i,
   input wire logic [37:0] pad_oe_i,
   input wire logic [37:0] board_level_i,
   output logic [37:0] pad_level_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // a released pad shows the board driver, never the chip's last value
   assign pad_level_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & board_level_i);
endmodule

// >>> ppm_pin_mux_bench.sv
// self-checking bench for the peripheral pin mux
module ppm_pin_mux_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk_i = 1'b0;
   logic rst_i;
   logic [37:0] pad_in_i, pad_out_o, pad_oe_o, pin_o, ext, eo, eu, lv;
   logic port_m0_analog_sel_o, port_m0_data_i, port_m0_dir_i, second_dac_en_i;
   logic [5:0] port_p_data_i, port_p_dir_i, motor_pwm_i, pwm_ch_en_i, pwm_out_i;
   logic [6:0] port_q_data_i, port_q_dir_i;
   logic [7:0] port_s_data_i, port_s_dir_i, port_t_data_i, port_t_dir_i;
   logic [7:0] port_u_data_i, port_u_dir_i;
   logic pmf_en_i, pmf_status_en_i, spi_en_i, spi_master_i, spi_ss_out_i;
   logic spi_ss_oe_i, spi_sck_out_i, spi_mosi_out_i, spi_miso_out_i;
   logic spi_ss_in_o, spi_sck_in_o, spi_mosi_in_o, spi_miso_in_o;
   logic serial_interface_zero_tx_en_i, serial_interface_zero_tx_i, serial_interface_zero_rx_en_i, serial_interface_zero_rx_o;
   logic serial_interface_one_tx_en_i, serial_interface_one_tx_i, serial_interface_one_rx_en_i, serial_interface_one_rx_o;
   logic timer_zero_en_i, timer_one_en_i, timer_two_en_i, pwm_en_i;
   logic [2:0] pmf_pair_en_i, current_status_n_o;
   logic [3:0] pmf_fault_en_i, fault_o, routing_select_i;
   logic [3:0] timer_zero_ch_en_i, timer_zero_out_i, timer_zero_oe_i, timer_zero_capture_o;
   logic [3:0] timer_one_ch_en_i, timer_one_out_i, timer_one_oe_i, timer_one_capture_o;
   logic [3:0] timer_two_ch_en_i, timer_two_out_i, timer_two_oe_i, timer_two_capture_o;
   logic [25:0] pe;
   logic [223:0] r;
   int seed = 32'h65DC75DD;
   int err_count = 0;
   int checked = 0;
   int cyc = 0;
   wire [25:0] ps = {port_m0_analog_sel_o, current_status_n_o, fault_o,
      spi_ss_in_o, spi_sck_in_o, spi_mosi_in_o, spi_miso_in_o, serial_interface_one_rx_o,
      serial_interface_zero_rx_o, timer_two_capture_o, timer_one_capture_o, timer_zero_capture_o};

   ppm_pin_mux i_ppm_pin_mux (.*);
   ppm_board_model i_ppm_board_model (.pad_out_i(pad_out_o),
      .pad_oe_i(pad_oe_o), .board_level_i(ext), .pad_level_o(pad_in_i));

   always #5 mclk_i = ~mclk_i;

   task automatic end_of_test();
      $display("counts: checked %0d err_count %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // a hang must still reach the closing report
   always @(posedge mclk_i) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         err_count++;
         $display("unexpected cycle count expected below 4000 seen 4000");
         end_of_test();
      end
   end

   task automatic chk(input logic [37:0] seen, input logic [37:0] exp,
      input string what);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic apply();
      {port_m0_data_i, port_m0_dir_i, port_p_data_i, port_p_dir_i,
       port_q_data_i, port_q_dir_i, port_s_data_i, port_s_dir_i,
       port_t_data_i, port_t_dir_i, port_u_data_i, port_u_dir_i,
       second_dac_en_i, pmf_en_i, pmf_pair_en_i, motor_pwm_i,
       pmf_status_en_i, pmf_fault_en_i, spi_en_i, spi_master_i,
       spi_ss_out_i, spi_ss_oe_i, spi_sck_out_i, spi_mosi_out_i,
       spi_miso_out_i, serial_interface_zero_tx_en_i, serial_interface_zero_tx_i, serial_interface_zero_rx_en_i, serial_interface_one_tx_en_i,
       serial_interface_one_tx_i, serial_interface_one_rx_en_i, timer_zero_en_i, timer_zero_ch_en_i, timer_zero_out_i,
       timer_zero_oe_i, timer_one_en_i, timer_one_ch_en_i, timer_one_out_i, timer_one_oe_i, timer_two_en_i,
       timer_two_ch_en_i, timer_two_out_i, timer_two_oe_i, pwm_en_i, pwm_ch_en_i,
       pwm_out_i, routing_select_i, ext} = r[198:0];
   endtask

   function automatic void calc();
      logic own;
      eo = {port_u_dir_i, port_t_dir_i, port_s_dir_i, port_q_dir_i,
         port_p_dir_i, port_m0_dir_i};
      eu = {port_u_data_i, port_t_data_i, port_s_data_i, port_q_data_i,
         port_p_data_i, port_m0_data_i};
      if (second_dac_en_i) eo[0] = 1'b0;
      for (int k = 0; k < 3; k++) if (pmf_en_i && pmf_pair_en_i[k]) begin
         eo[2*k+1 +: 2] = 2'h3;
         eu[2*k+1 +: 2] = motor_pwm_i[2*k +: 2];
      end
      if (pmf_en_i && pmf_status_en_i) eo[13:11] = 3'h0;
      eo[10:7] = eo[10:7] & ~(pmf_fault_en_i & {4{pmf_en_i}});
      if (spi_en_i) begin
         eo[21:18] = {spi_ss_oe_i, spi_master_i, spi_master_i, !spi_master_i};
         eu[21:18] = {spi_ss_out_i, spi_sck_out_i, spi_mosi_out_i,
            spi_miso_out_i};
      end
      if (serial_interface_one_tx_en_i) {eo[17], eu[17]} = {1'b1, serial_interface_one_tx_i};
      if (serial_interface_zero_tx_en_i) {eo[15], eu[15]} = {1'b1, serial_interface_zero_tx_i};
      if (serial_interface_one_rx_en_i) eo[16] = 1'b0;
      if (serial_interface_zero_rx_en_i) eo[14] = 1'b0;
      for (int k = 0; k < 6; k++) begin
         own = pwm_en_i && pwm_ch_en_i[k] && (k > 3 || !routing_select_i[k%4]);
         if (own) {eo[30+k], eu[30+k]} = {1'b1, pwm_out_i[k]};
      end
      for (int k = 0; k < 4; k++) begin
         if (timer_zero_en_i && timer_zero_ch_en_i[k])
            {eo[22+k], eu[22+k]} = {timer_zero_oe_i[k], timer_zero_out_i[k]};
         if (timer_one_en_i && timer_one_ch_en_i[k])
            {eo[26+k], eu[26+k]} = {timer_one_oe_i[k], timer_one_out_i[k]};
         if (timer_two_en_i && timer_two_ch_en_i[k] && routing_select_i[k])
            {eo[30+k], eu[30+k]} = {timer_two_oe_i[k], timer_two_out_i[k]};
      end
      lv = (eo & eu) | (~eo & ext);
      for (int k = 0; k < 4; k++) begin
         pe[k] = timer_zero_en_i & timer_zero_ch_en_i[k] & lv[22+k];
         pe[4+k] = timer_one_en_i & timer_one_ch_en_i[k] & lv[26+k];
         pe[8+k] = timer_two_en_i & timer_two_ch_en_i[k] & routing_select_i[k] & lv[30+k];
      end
      pe[25:12] = {second_dac_en_i,
         (pmf_en_i && pmf_status_en_i) ? lv[13:11] : 3'h7,
         pmf_fault_en_i & {4{pmf_en_i}} & lv[10:7],
         spi_en_i ? lv[21:18] : 4'hF,
         serial_interface_one_rx_en_i ? lv[16] : 1'b1, serial_interface_zero_rx_en_i ? lv[14] : 1'b1};
   endfunction

   // first steps are corner patterns: all off, all on, alternating bits
   task automatic step(input int i);
      case (i)
         0: r = '0;
         1: r = '1;
         2: r = {7{32'h5555_5555}};
         3: r = {7{32'hAAAA_AAAA}};
         default: r = {$random(seed), $random(seed), $random(seed),
            $random(seed), $random(seed), $random(seed), $random(seed)};
      endcase
      apply();
      repeat (5) @(posedge mclk_i);
      #1;
      calc();
      chk(pad_oe_o, eo, "pad_oe_o");
      chk(pad_out_o & eo, eu & eo, "pad_out_o");
      chk(pin_o, lv, "pin_o");
      chk({12'h000, ps}, {12'h000, pe}, "peripheral side");
   endtask

   // every enable is set while reset is held: no pin may be driven
   task automatic rst_test();
      rst_i = 1'b1;
      r = '1;
      apply();
      repeat (2) @(posedge mclk_i);
      #1;
      chk(pad_oe_o, '0, "pad_oe_o in reset");
      chk(pad_out_o | pin_o, '0, "pad_out_o or pin_o in reset");
      chk({12'h000, ps}, {12'h000, 1'b0, 3'h7, 4'h0, 4'hF, 2'h3, 12'h000},
         "peripheral side in reset");
      rst_i = 1'b0;
      $display("test reset done");
   endtask

   initial begin
      rst_test();
      for (int i = 0; i < 300; i++) step(i);
      $display("test random mux done");
      rst_test();
      for (int i = 0; i < 20; i++) step(i + 4);
      $display("test after second reset done");
      end_of_test();
   end
endmodule
